// [logic/ee_i2c_slave.sv]
// two-wire serial eeprom slave: bus front end, page buffer and memory array
`timescale 1ns/1ps
`include "ee_defs.svh"

// Summary of operation
// R1: start is falling data while clock high
// R2: stop after write programs, else standby
// R3: data changes only while clock low
// R4: zero pulls line low, one releases it
// R5: chip select bits compared with straps
// R6: last address bit gives transfer direction
// R7: matching address acknowledged on ninth clock
// R8: write acknowledges address and data bytes
// R9: read releases ninth clock, continues on ack
// R10: master ends read with no-ack, stop
// R11: byte write: four bytes all acknowledged
// R12: no address acknowledge while programming
// R13: 512 pages of 128 bytes each
// R14: write index wraps inside the page
// R15: protect pin high rejects first data byte
// R16: protect pin low allows all writes
// R17: memory starts fully erased
// R18: counter points after last byte, wraps
// R19: read address sends byte at counter
// R20: selective read uses dummy write, restart
// R21: sequential read continues, wraps at end
// R22: busy shown by missing acknowledge
// R23: sample on rising, drive on falling
// R24: mismatch releases line until next start
module ee_i2c_slave #(
    parameter int WR_CYC = `EE_WR_CYC,
    parameter logic [3:0] TYPE_PREFIX = `EE_TYPE_PREFIX
) (
    // clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // two-wire bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // straps and protection
    input wire logic wp_i,
    input wire logic chip_select_strap_bit0_i,
    input wire logic chip_select_strap_bit1_i,
    input wire logic chip_select_strap_bit2_i,
    // status
    output logic busy_o
);
    localparam int PW = $clog2(WR_CYC + 1);
    // input synchronisers, first and second stage
    logic [5:0] in_m_q;
    logic [5:0] in_s_q;
    // previous synchronised clock and data
    logic scl_p_q;
    logic sda_p_q;
    // bus state and bit counter
    ee_pkg::ee_state_e st_q;
    logic [3:0] bcnt_q;
    // receive and transmit shifters
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    // data line drive, direction, master ack, protect sample
    logic oe_q;
    logic rw_q;
    logic mack_q;
    logic wp_q;
    logic wpend_q;
    // address counter
    logic [`EE_ADDR_W-1:0] addr_q;
    // page buffer and its byte valid flags
    logic [7:0] pbuf [0:`EE_PAGE_BYTES-1];
    logic [`EE_PAGE_BYTES-1:0] valid_q;
    // programming cycle
    logic busy_q;
    logic [PW-1:0] pcnt_q;
    logic [`EE_ADDR_W-`EE_PAGE_W-1:0] page_q;
    // memory array, erased at start
    logic [7:0] mem [0:(1<<`EE_ADDR_W)-1] = '{default: `EE_ERASED}; // R17 R13
    // decoded bus events
    logic scl_s;
    logic sda_s;
    logic start_w;
    logic stop_w;
    logic rise_w;
    logic fall_w;
    logic dev_hit_w;
    logic wr_byte_w;
    logic alo_end_w;
    logic prog_go_w;
    logic [7:0] rd_byte_w;
    assign scl_s = in_s_q[5];
    assign sda_s = in_s_q[4];
    assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s; // R1 R3
    assign stop_w = scl_s & scl_p_q & ~sda_p_q & sda_s; // R2 R3
    assign rise_w = scl_s & ~scl_p_q;
    assign fall_w = ~scl_s & scl_p_q;
    // address match with prefix, straps, and not busy
    assign dev_hit_w = (sh_q[7:4] == TYPE_PREFIX) && (sh_q[3:1] == in_s_q[2:0])
                       && !busy_q; // R5 R12 R22
    // a data byte accepted into the page buffer
    assign wr_byte_w = fall_w && (bcnt_q == `EE_BIT_ACK) && (st_q == ee_pkg::EE_WR)
                       && !wp_q; // R15 R16
    assign alo_end_w = fall_w && (bcnt_q == `EE_BIT_END) && (st_q == ee_pkg::EE_ALO);
    assign prog_go_w = stop_w && (st_q == ee_pkg::EE_WR) && wpend_q; // R2
    assign rd_byte_w = mem[addr_q];
    // open drain: only ever pulls low
    assign sda_o = 1'b0; // R4
    assign sda_oe_o = oe_q;
    assign busy_o = busy_q;
    // two-stage synchronisers and edge history
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            in_m_q <= `EE_IN_RST;
            in_s_q <= `EE_IN_RST;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (clk_en_i) begin
            in_m_q <= {scl_i, sda_i, wp_i, chip_select_strap_bit2_i,
                       chip_select_strap_bit1_i, chip_select_strap_bit0_i};
            in_s_q <= in_m_q;
            scl_p_q <= in_s_q[5];
            sda_p_q <= in_s_q[4];
        end
    end

    // bus state machine, shifters, ack drive and address counter
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= ee_pkg::EE_IDLE;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            oe_q <= 1'b0;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            wp_q <= 1'b0;
            wpend_q <= 1'b0;
            addr_q <= '0;
        end else if (clk_en_i) begin
            if (start_w) begin
                // start or repeated start: fresh address byte
                st_q <= ee_pkg::EE_DEV; // R1
                bcnt_q <= 4'h0;
                oe_q <= 1'b0;
                wpend_q <= 1'b0;
            end else if (stop_w) begin
                // stop: back to standby, counter kept
                st_q <= ee_pkg::EE_IDLE; // R2 R18
                bcnt_q <= 4'h0;
                oe_q <= 1'b0;
                wpend_q <= 1'b0;
            end else if (st_q != ee_pkg::EE_IDLE && st_q != ee_pkg::EE_IGN) begin
                if (rise_w) begin
                    // sample data on the rising edge
                    if (bcnt_q < `EE_BIT_ACK) begin
                        sh_q <= {sh_q[6:0], sda_s}; // R23
                        bcnt_q <= bcnt_q + 4'h1;
                    end else if (bcnt_q == `EE_BIT_END) begin
                        mack_q <= ~sda_s; // R9
                    end
                end else if (fall_w) begin
                    // drive changes only on the falling edge
                    if (bcnt_q == `EE_BIT_ACK) begin
                        bcnt_q <= `EE_BIT_END;
                        case (st_q)
                            ee_pkg::EE_DEV: begin
                                oe_q <= dev_hit_w; // R7 R12 R24
                                rw_q <= sh_q[0]; // R6
                            end
                            ee_pkg::EE_AHI: begin
                                oe_q <= 1'b1; // R8 R11
                                addr_q[15:8] <= sh_q;
                            end
                            ee_pkg::EE_ALO: begin
                                oe_q <= 1'b1; // R8 R11
                                addr_q[7:0] <= sh_q;
                            end
                            ee_pkg::EE_WR: begin
                                oe_q <= ~wp_q; // R15 R16 R8
                                if (!wp_q) begin
                                    // in-page index only
                                    addr_q[6:0] <= addr_q[6:0] + 7'h01; // R14
                                    wpend_q <= 1'b1;
                                end
                            end
                            default: begin
                                // read: release for master ack
                                oe_q <= 1'b0; // R9
                            end
                        endcase
                    end else if (bcnt_q == `EE_BIT_END) begin
                        bcnt_q <= 4'h0;
                        oe_q <= 1'b0;
                        case (st_q)
                            ee_pkg::EE_DEV: begin
                                if (!oe_q) begin
                                    st_q <= ee_pkg::EE_IGN; // R24 R12
                                end else if (rw_q) begin
                                    // read: send byte at counter
                                    st_q <= ee_pkg::EE_RD; // R19
                                    tx_q <= rd_byte_w;
                                    oe_q <= ~rd_byte_w[7];
                                    addr_q <= addr_q + 16'h0001; // R18
                                end else begin
                                    st_q <= ee_pkg::EE_AHI;
                                end
                            end
                            ee_pkg::EE_AHI: begin
                                st_q <= ee_pkg::EE_ALO;
                            end
                            ee_pkg::EE_ALO: begin
                                // protect pin strobed before first data byte
                                st_q <= ee_pkg::EE_WR;
                                wp_q <= in_s_q[3]; // R15
                            end
                            ee_pkg::EE_WR: begin
                                if (!oe_q) begin
                                    st_q <= ee_pkg::EE_IGN; // R15
                                end
                            end
                            ee_pkg::EE_RD: begin
                                if (mack_q) begin
                                    // next byte, whole-memory wrap
                                    tx_q <= rd_byte_w; // R21
                                    oe_q <= ~rd_byte_w[7];
                                    addr_q <= addr_q + 16'h0001; // R21
                                end else begin
                                    st_q <= ee_pkg::EE_IGN; // R10
                                end
                            end
                            default: begin
                                st_q <= ee_pkg::EE_IGN;
                            end
                        endcase
                    end else if (st_q == ee_pkg::EE_RD) begin
                        // next read bit, msb first
                        tx_q <= {tx_q[6:0], 1'b0};
                        oe_q <= ~tx_q[6]; // R4 R23
                    end
                end
            end
        end
    end
    // page buffer fill
    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && wr_byte_w) begin
            pbuf[addr_q[6:0]] <= sh_q; // R14
        end
    end
    // byte valid flags, cleared when a write session begins
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valid_q <= '0;
        end else if (clk_en_i) begin
            if (alo_end_w) begin
                valid_q <= '0;
            end else if (wr_byte_w) begin
                valid_q[addr_q[6:0]] <= 1'b1;
            end
        end
    end
    // programming cycle timer
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_q <= 1'b0;
            pcnt_q <= '0;
            page_q <= '0;
        end else if (clk_en_i) begin
            if (prog_go_w && !busy_q) begin
                busy_q <= 1'b1; // R2
                pcnt_q <= '0;
                page_q <= addr_q[15:7]; // R13
            end else if (busy_q) begin
                pcnt_q <= pcnt_q + PW'(1);
                if (pcnt_q == PW'(WR_CYC - 1)) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end
    // copy valid buffer bytes into the array during programming
    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && busy_q && pcnt_q < PW'(`EE_PAGE_BYTES)) begin
            if (valid_q[pcnt_q[6:0]]) begin
                mem[{page_q, pcnt_q[6:0]}] <= pbuf[pcnt_q[6:0]]; // R14
            end
        end
    end
    // checks on the bus logic
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i || !clk_en_i);
    property p_start;
        start_w |=> st_q == ee_pkg::EE_DEV && bcnt_q == 4'h0 && !oe_q;
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // R1
    property p_prog;
        prog_go_w && !busy_q |=> busy_q ##1 busy_q;
    endproperty
    a_prog: assert property (p_prog) else $error("no programming on stop"); // R2
    property p_busy_nak;
        busy_q && st_q == ee_pkg::EE_DEV && fall_w && bcnt_q == `EE_BIT_ACK |=> !oe_q;
    endproperty
    a_busy_nak: assert property (p_busy_nak) else $error("ack while busy"); // R12
    property p_dev_ack;
        st_q == ee_pkg::EE_DEV && fall_w && bcnt_q == `EE_BIT_ACK && dev_hit_w
            |=> oe_q && bcnt_q == `EE_BIT_END;
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("address not acked"); // R7
    property p_ign;
        st_q == ee_pkg::EE_IGN |-> !oe_q;
    endproperty
    a_ign: assert property (p_ign) else $error("drive while ignoring"); // R24
    property p_wp;
        st_q == ee_pkg::EE_WR && fall_w && bcnt_q == `EE_BIT_ACK && wp_q
            |=> !oe_q && !wpend_q;
    endproperty
    a_wp: assert property (p_wp) else $error("protected byte acked"); // R15
    property p_wr_ack;
        wr_byte_w |=> oe_q && wpend_q;
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("data byte not acked"); // R16
    property p_page;
        wr_byte_w |=> addr_q[15:7] == $past(addr_q[15:7])
            && addr_q[6:0] == $past(addr_q[6:0]) + 7'h01;
    endproperty
    a_page: assert property (p_page) else $error("page index wrong"); // R14
    property p_seq;
        st_q == ee_pkg::EE_RD && fall_w && bcnt_q == `EE_BIT_END && mack_q
            |=> addr_q == $past(addr_q) + 16'h0001;
    endproperty
    a_seq: assert property (p_seq) else $error("read counter wrong"); // R21
    property p_edge;
        $rose(oe_q) |-> !scl_s;
    endproperty
    a_edge: assert property (p_edge) else $error("drive while clock high"); // R23
endmodule

// [logic/ee_defs.svh]
// constants for the two-wire serial eeprom slave
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH
// system clock rate in MHz
`define EE_CLK_MHZ 200
// internal programming time in ms
`define EE_T_WR_MS 5
// programming time in system clock cycles
`define EE_WR_CYC (`EE_T_WR_MS * 1000 * `EE_CLK_MHZ)
// memory geometry
`define EE_ADDR_W 16
`define EE_PAGE_W 7
`define EE_PAGE_BYTES 128
// erased byte value
`define EE_ERASED 8'hff
// bit counter values: last data bit done, acknowledge clock
`define EE_BIT_ACK 4'h8
`define EE_BIT_END 4'h9
// reset value of the synchronised inputs {scl, sda, wp, straps}
`define EE_IN_RST 6'h30
// arbitrary neutral device type prefix
`define EE_TYPE_PREFIX 4'h5
`endif

// [logic/ee_pkg.sv]
// types for the two-wire serial eeprom slave
package ee_pkg;
    // bus state, gray coded along idle-dev-ahi-alo-wr
    typedef enum logic [2:0] {
        EE_IDLE = 3'h0,
        EE_DEV  = 3'h1,
        EE_AHI  = 3'h3,
        EE_ALO  = 3'h2,
        EE_WR   = 3'h6,
        EE_RD   = 3'h7,
        EE_IGN  = 3'h5
    } ee_state_e;
endpackage

// [dv/ee_bus_master.sv]
// two-wire bus master model that drives the serial clock and the data pull-down
`timescale 1ns/1ps
module ee_bus_master (
    // bus pins
    output logic scl_o,
    output logic sda_pull_o,
    input wire logic sda_i
);
    // quarter of the 48 ns link clock period
    localparam int Q = 12;

    // bus idles with clock high and data released
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    // start or repeated start, ends with clock low
    task automatic start_cond();
        #Q sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b0;
    endtask

    // pull the clock low from an idle bus without a start condition
    task automatic clock_low();
        #Q scl_o = 1'b0;
    endtask

    // stop, clock stands still high afterwards
    task automatic stop_cond();
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b0;
        #(2*Q);
    endtask

    // one clock: data set mid low phase, sampled just before the fall
    task automatic bit_cycle(input logic b, output logic got);
        #Q sda_pull_o = ~b;
        #Q scl_o = 1'b1;
        #(2*Q) got = sda_i;
        scl_o = 1'b0;
    endtask

    // send a byte msb first, return the acknowledge seen on the ninth clock
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], g);
        end
        bit_cycle(1'b1, g);
        ack = ~g;
    endtask

    // receive a byte msb first, then acknowledge or leave it unacknowledged
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, g);
            d[i] = g;
        end
        bit_cycle(~ack, g);
    endtask
endmodule

// [dv/ee_i2c_slave_tb_top.sv]
// self-checking testbench for the two-wire serial eeprom slave
`timescale 1ns/1ps
module ee_i2c_slave_tb_top;
    // short programming time for simulation
    localparam int WR_CYC = 200;
    // arbitrary neutral device type prefix
    localparam logic [3:0] PFX = 4'h5;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp = 1'b0;
    logic [2:0] strap = 3'h5;
    logic sda_o;
    logic sda_oe;
    logic busy;
    wire scl;
    wire m_pull;
    // wired-and data line with pull-up
    wire sda = ~(m_pull | (sda_oe & ~sda_o));
    int n_fail = 0;
    int comparisons = 0;
    logic [7:0] rd_q[$];

    always #2.5 clk = ~clk;

    ee_i2c_slave #(.WR_CYC(WR_CYC), .TYPE_PREFIX(PFX)) dut (
        .clk_sys_i(clk), .reset_n_i(reset_n), .clk_en_i(1'b1),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .wp_i(wp), .chip_select_strap_bit0_i(strap[0]),
        .chip_select_strap_bit1_i(strap[1]), .chip_select_strap_bit2_i(strap[2]),
        .busy_o(busy)
    );

    ee_bus_master m (.scl_o(scl), .sda_pull_o(m_pull), .sda_i(sda));

    // device output may only move while the clock is low
    always @(sda_oe) begin
        if (reset_n === 1'b1 && scl === 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: data output moved with clock high", $time);
        end
    end

    // compare one value and count it
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // start, write-direction address and two memory address bytes
    task automatic set_addr(input logic [15:0] a);
        logic k;
        m.start_cond();
        m.put_byte({PFX, strap, 1'b0}, k);
        check(8'(k), 8'h01, "device ack");
        m.put_byte(a[15:8], k);
        check(8'(k), 8'h01, "high address ack");
        m.put_byte(a[7:0], k);
        check(8'(k), 8'h01, "low address ack");
    endtask

    // programming follows a stop and refuses the address until done
    task automatic wait_ready();
        logic k;
        repeat (2) @(posedge clk);
        check(8'(busy), 8'h01, "busy after stop");
        m.start_cond();
        m.put_byte({PFX, strap, 1'b0}, k);
        m.stop_cond();
        check(8'(k), 8'h00, "ack while programming");
        for (int i = 0; i < 40 && k !== 1'b1; i++) begin
            m.start_cond();
            m.put_byte({PFX, strap, 1'b0}, k);
            m.stop_cond();
        end
        check(8'(k), 8'h01, "ready after programming");
    endtask

    // write n bytes counting up from v0, then let the cycle finish
    task automatic write_bytes(input logic [15:0] a, input int n, input logic [7:0] v0);
        logic k;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            m.put_byte(v0 + i[7:0], k);
            check(8'(k), 8'h01, "data ack");
        end
        m.stop_cond();
        wait_ready();
    endtask

    // selective or immediate read of n bytes into rd_q
    task automatic rd(input logic sel, input logic [15:0] a, input int n);
        logic k;
        logic [7:0] d;
        rd_q.delete();
        if (sel) begin
            set_addr(a);
        end
        m.start_cond();
        m.put_byte({PFX, strap, 1'b1}, k);
        check(8'(k), 8'h01, "read address ack");
        for (int i = 0; i < n; i++) begin
            m.get_byte(i < n - 1, d);
            rd_q.push_back(d);
        end
        m.stop_cond();
    endtask

    // only the matching straps and prefix are answered
    task automatic t_straps();
        logic k;
        logic k2;
        for (int s = 0; s < 9; s++) begin
            m.start_cond();
            m.put_byte((s == 8) ? {PFX ^ 4'h8, strap, 1'b0} : {PFX, s[2:0], 1'b0}, k);
            m.put_byte(8'h00, k2);
            m.stop_cond();
            check(8'(k), 8'(s[2:0] == strap && s < 8), "strap select ack");
            check(8'(k2), 8'(s[2:0] == strap && s < 8), "ack after mismatch");
        end
    endtask

    // a byte without a start is ignored; clock goes low first so data never moves while high before the stop
    task automatic t_no_start();
        logic k;
        m.clock_low();
        m.put_byte({PFX, strap, 1'b0}, k);
        m.stop_cond();
        check(8'(k), 8'h00, "ack without start");
    endtask

    // 130 bytes from index 7e of page 5 wrap inside the page
    task automatic t_page();
        write_bytes({9'h005, 7'h7e}, 130, 8'h00);
        rd(1'b1, {9'h005, 7'h7e}, 3);
        check(rd_q[0], 8'h80, "page byte 7e");
        check(rd_q[1], 8'h81, "page byte 7f");
        check(rd_q[2], 8'hff, "next page erased");
        rd(1'b1, {9'h005, 7'h00}, 1);
        check(rd_q[0], 8'h02, "page byte 00");
        rd(1'b0, 16'h0000, 1);
        check(rd_q[0], 8'h03, "immediate read");
    endtask

    // sequential read rolls over from the top of memory to zero
    task automatic t_wrap();
        write_bytes(16'h0000, 1, 8'h11);
        write_bytes(16'hffff, 1, 8'h5a);
        rd(1'b1, 16'hffff, 2);
        check(rd_q[0], 8'h5a, "top byte");
        check(rd_q[1], 8'h11, "wrapped byte");
        rd(1'b0, 16'h0000, 1);
        check(rd_q[0], 8'hff, "counter after wrap");
    endtask

    // protect pin high refuses the first data byte and the write
    task automatic t_wp();
        logic k;
        @(posedge clk);
        #1 wp = 1'b1;
        set_addr(16'h0200);
        m.put_byte(8'h33, k);
        check(8'(k), 8'h00, "protected data ack");
        m.stop_cond();
        repeat (4) @(posedge clk);
        check(8'(busy), 8'h00, "busy after protected write");
        #1 wp = 1'b0;
        rd(1'b1, 16'h0200, 1);
        check(rd_q[0], 8'hff, "protected byte unchanged");
    endtask

    // print the verdict and end the run
    task automatic report_and_stop();
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1 reset_n = 1'b1;
        repeat (3) @(posedge clk);
        t_straps();
        t_no_start();
        t_page();
        t_wrap();
        t_wp();
        report_and_stop();
    end

    // watchdog well past the expected run length
    initial begin
        #400000;
        n_fail++;
        report_and_stop();
    end
endmodule
